// ### watchdog_sleep_pkg.sv
// Constants and types shared by the watchdog and sleep control block
package watchdog_sleep_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  // Nominal period of one tick of the always-on RC oscillator
  localparam int RC_TICK_NS = 1000;
  localparam int RC_TICK_CYCLES = (RC_TICK_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  // Unscaled watchdog period, counted in RC ticks
  localparam int WDT_BASE_PERIOD_US = 18000;
  localparam int WDT_BASE_TICKS = (WDT_BASE_PERIOD_US * 1000) / RC_TICK_NS;
  localparam int RC_CNT_W = 16;
  localparam int WDT_CNT_W = 24;
  localparam int PRE_CNT_W = 8;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [13:0] IDX_STATUS = 14'h0003;
  localparam logic [13:0] IDX_INTCTL = 14'h000b;
  localparam logic [13:0] IDX_IRQ_EN = 14'h000c;
  localparam logic [13:0] IDX_CMD = 14'h0040;
  localparam logic [13:0] IDX_OPTION = 14'h0081;
  localparam logic [13:0] IDX_FUSE = 14'h2007;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PD_BIT = 3;
  localparam int STAT_ASLEEP_BIT = 0;
  localparam int GIE_BIT = 7;
  localparam int PSA_BIT = 3;
  localparam int PS_MSB = 2;
  localparam int FUSE_WATCHDOG_ENABLE_FUSE_BIT = 2;
  localparam int CMD_WATCHDOG_CLEAR_INSTRUCTION_BIT = 0;
  localparam int CMD_SLEEP_BIT = 1;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  // Program address taken when vector_pulse fires
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // ----------------------------------------------------------------------
  // Core power state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} core_state_e;

endpackage : watchdog_sleep_pkg

// ### watchdog_sleep_wakeup_control.sv
// Watchdog timer with sleep entry and wake-up control, Avalon-MM slave
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps

// Contract
// - Watchdog counts from its own oscillator tick, running on through sleep.
// - Time-out while running issues a full watchdog reset.
// - Time-out while asleep wakes the core instead of resetting.
// - Cleared enable fuse disables the watchdog: no resets, no wake-ups.
// - Unscaled period is 18 ms, held as a count of oscillator ticks.
// - Option register can assign the prescaler, dividing up to 1:128.
// - Clear and sleep commands zero the counter and an assigned prescaler.
// - After sleep executes, time-out only wakes, never resets.
// - Every time-out clears the time-out status flag.
// - Clearing zeroes the prescaler count but keeps assignment and ratio.
// - Sleep entry clears power-down flag, sets time-out flag, stops oscillator.
// - During sleep all I/O pins hold their previous drive state.
// - Power-down flag set at power-up, cleared by sleep.
// - Master clear resets during sleep; time-out or interrupt wake instead.
// - Only sources working without the core clock can wake the device.
// - Sleep prefetches the instruction at the next program address.
// - Enabled interrupt wakes regardless of global interrupt enable.
// - After interrupt wake, run next instruction, then vector if enabled.
// - Enabled interrupt pending before sleep makes sleep a no-op.
// - Interrupt during or after sleep: sleep completes, then wakes at once.
// - Global interrupt enable is bit 7 and cleared by every reset.
module watchdog_sleep_wakeup_control #(
  parameter int IRQ_N = 8,
  parameter logic [7:0] WAKE_MASK = 8'h0f,
  parameter int BASE_TICKS = watchdog_sleep_pkg::WDT_BASE_TICKS,
  parameter int RC_DIV = watchdog_sleep_pkg::RC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Avalon-MM register slave
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins and fuses
  input wire logic master_clear_pin_n,
  input wire logic [7:0] config_fuses,
  input wire logic [IRQ_N-1:0] irq_flags,
  // Core control
  output logic wdt_reset_pulse,
  output logic wake_pulse,
  output logic vector_pulse,
  output logic prefetch_pulse,
  output logic osc_run,
  output logic io_hold
);
  import watchdog_sleep_pkg::*;

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (IRQ_N < 1 || IRQ_N > 8) begin : g_chk_irq
    $error("IRQ_N must lie between 1 and 8");
  end
  if (BASE_TICKS < 1 || BASE_TICKS >= (1 << WDT_CNT_W)) begin : g_chk_base
    $error("BASE_TICKS out of range");
  end
  if (RC_DIV < 1 || RC_DIV >= (1 << RC_CNT_W)) begin : g_chk_div
    $error("RC_DIV out of range");
  end

  localparam logic [WDT_CNT_W-1:0] BASE_LAST = WDT_CNT_W'(BASE_TICKS - 1);
  localparam logic [RC_CNT_W-1:0] RC_LAST = RC_CNT_W'(RC_DIV - 1);
  localparam logic [7:0] EN_MASK = 8'((9'h001 << IRQ_N) - 9'h001);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    core_state_e st;
    logic [RC_CNT_W-1:0] rc_cnt;
    logic [WDT_CNT_W-1:0] base_cnt;
    logic [PRE_CNT_W-1:0] pre_cnt;
    logic tmo;
    logic [7:0] option;
    logic [7:0] irq_en;
    logic global_irq_enable;
    logic tof;
    logic pdf;
    logic vec_pend;
    logic wait_n;
    logic [7:0] rdata;
    logic wdt_rst;
    logic wake;
    logic vec;
    logic prefetch;
    logic osc_run;
    logic io_hold;
  } blk_state_s;

  blk_state_s r_reg;
  blk_state_s r_next;

  // Address decode shared by reads, writes and commands
  function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
    return a[15:2] == idx;
  endfunction : hit

  // Prescaler terminal count for ratio 1:2^ps
  function automatic logic [PRE_CNT_W-1:0] ratio_last(input logic [2:0] ps);
    return PRE_CNT_W'((9'h001 << ps) - 9'h001);
  endfunction : ratio_last

  // ----------------------------------------------------------------------
  // Decoded events
  // ----------------------------------------------------------------------
  logic bus_wr;
  logic cmd_clr;
  logic cmd_sleep;
  logic irq_act;
  logic irq_wake;
  logic fuse_en;
  logic rc_tick;
  logic prescaler_assign_select;

  // A write takes effect at the edge where waitrequest is seen low
  assign bus_wr = avs_write && !r_reg.wait_n && avs_byteenable[0];
  assign cmd_clr = bus_wr && hit(avs_address, IDX_CMD)
                   && avs_writedata[CMD_WATCHDOG_CLEAR_INSTRUCTION_BIT] && r_reg.st == ST_RUN;
  assign cmd_sleep = bus_wr && hit(avs_address, IDX_CMD)
                     && avs_writedata[CMD_SLEEP_BIT] && r_reg.st == ST_RUN;
  // Any enabled interrupt pending turns sleep into a no-op
  assign irq_act = |(irq_flags & r_reg.irq_en[IRQ_N-1:0]);
  // Only sources that run without the core clock may wake
  assign irq_wake = |(irq_flags & r_reg.irq_en[IRQ_N-1:0]
                      & WAKE_MASK[IRQ_N-1:0]);
  assign fuse_en = config_fuses[FUSE_WATCHDOG_ENABLE_FUSE_BIT];
  assign rc_tick = r_reg.rc_cnt == RC_LAST;
  assign prescaler_assign_select = r_reg.option[PSA_BIT];

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.wdt_rst = 1'b0;
    r_next.wake = 1'b0;
    r_next.vec = 1'b0;
    r_next.prefetch = 1'b0;
    r_next.tmo = 1'b0;

    // Free-running tick divider; never gated by sleep
    r_next.rc_cnt = rc_tick ? '0 : r_reg.rc_cnt + 1'b1;

    // Watchdog counter and optional prescaler, on oscillator ticks only
    if (fuse_en && rc_tick) begin
      if (r_reg.base_cnt == BASE_LAST) begin
        r_next.base_cnt = '0;
        if (prescaler_assign_select) begin
          if (r_reg.pre_cnt == ratio_last(r_reg.option[PS_MSB:0])) begin
            r_next.pre_cnt = '0;
            r_next.tmo = 1'b1;
          end else begin
            r_next.pre_cnt = r_reg.pre_cnt + 1'b1;
          end
        end else begin
          r_next.tmo = 1'b1;
        end
      end else begin
        r_next.base_cnt = r_reg.base_cnt + 1'b1;
      end
    end

    // Avalon handshake: lower waitrequest for one cycle per request
    if (!r_reg.wait_n) begin
      r_next.wait_n = 1'b1;
    end else if (avs_read || avs_write) begin
      r_next.wait_n = 1'b0;
      r_next.rdata = 8'h00;
      if (hit(avs_address, IDX_STATUS)) begin
        r_next.rdata[STAT_TO_BIT] = r_reg.tof;
        r_next.rdata[STAT_PD_BIT] = r_reg.pdf;
        r_next.rdata[STAT_ASLEEP_BIT] = r_reg.st == ST_SLEEP;
      end else if (hit(avs_address, IDX_INTCTL)) begin
        r_next.rdata[GIE_BIT] = r_reg.global_irq_enable;
      end else if (hit(avs_address, IDX_IRQ_EN)) begin
        r_next.rdata = r_reg.irq_en;
      end else if (hit(avs_address, IDX_OPTION)) begin
        r_next.rdata = r_reg.option;
      end else if (hit(avs_address, IDX_FUSE)) begin
        r_next.rdata = config_fuses;
      end
    end

    // Plain register writes
    if (bus_wr && hit(avs_address, IDX_OPTION)) begin
      r_next.option = avs_writedata[7:0];
    end
    if (bus_wr && hit(avs_address, IDX_INTCTL)) begin
      r_next.global_irq_enable = avs_writedata[GIE_BIT];
    end
    if (bus_wr && hit(avs_address, IDX_IRQ_EN)) begin
      r_next.irq_en = avs_writedata[7:0] & EN_MASK;
    end

    // Reset sources first, then the power state machine
    if (!master_clear_pin_n) begin
      // External reset, also out of sleep; status flags keep their values
      r_next.st = ST_RUN;
      r_next.osc_run = 1'b1;
      r_next.io_hold = 1'b0;
      r_next.global_irq_enable = 1'b0;
      r_next.option = OPTION_RESET;
      r_next.irq_en = IRQ_EN_RESET;
      r_next.base_cnt = '0;
      r_next.pre_cnt = '0;
      r_next.vec_pend = 1'b0;
      r_next.tmo = 1'b0;
    end else if (r_reg.tmo && r_reg.st != ST_SLEEP) begin
      // Time-out while running is a full watchdog reset
      r_next.wdt_rst = 1'b1;
      r_next.tof = 1'b0;
      r_next.st = ST_RUN;
      r_next.global_irq_enable = 1'b0;
      r_next.option = OPTION_RESET;
      r_next.irq_en = IRQ_EN_RESET;
      r_next.base_cnt = '0;
      r_next.pre_cnt = '0;
      r_next.vec_pend = 1'b0;
    end else if (r_reg.tmo) begin
      // Asleep, so the time-out only wakes; no vector follows
      r_next.wake = 1'b1;
      r_next.tof = 1'b0;
      r_next.st = ST_WAKE;
      r_next.vec_pend = 1'b0;
      r_next.osc_run = 1'b1;
      r_next.io_hold = 1'b0;
    end else begin
      unique case (r_reg.st)
        ST_RUN: begin
          // Clear command: zero the count, keep assignment and ratio
          if (cmd_clr || (cmd_sleep && !irq_act)) begin
            r_next.base_cnt = '0;
            r_next.tmo = 1'b0;
            if (prescaler_assign_select) begin
              r_next.pre_cnt = '0;
            end
          end
          if (cmd_sleep) begin
            r_next.prefetch = 1'b1;
            // A pending enabled interrupt leaves everything but the prefetch untouched
            if (!irq_act) begin
              r_next.pdf = 1'b0;
              r_next.tof = 1'b1;
              r_next.osc_run = 1'b0;
              r_next.io_hold = 1'b1;
              r_next.st = ST_SLEEP;
            end
          end
        end
        ST_SLEEP: begin
          // A late interrupt is seen here, after sleep has completed
          if (irq_wake) begin
            r_next.wake = 1'b1;
            r_next.st = ST_WAKE;
            r_next.vec_pend = r_reg.global_irq_enable;
            r_next.osc_run = 1'b1;
            r_next.io_hold = 1'b0;
          end
        end
        ST_WAKE: begin
          // Instruction after sleep runs here; vector only afterwards
          r_next.st = ST_RUN;
          r_next.vec = r_reg.vec_pend;
          r_next.vec_pend = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Power-on reset; the only place the power-down flag is set
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r_reg <= '0;
      r_reg.st <= ST_RUN;
      r_reg.option <= OPTION_RESET;
      r_reg.irq_en <= IRQ_EN_RESET;
      r_reg.global_irq_enable <= 1'b0;
      r_reg.tof <= 1'b1;
      r_reg.pdf <= 1'b1;
      r_reg.wait_n <= 1'b1;
      r_reg.osc_run <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state flops
  assign avs_readdata = {24'h000000, r_reg.rdata};
  assign avs_waitrequest = r_reg.wait_n;
  assign wdt_reset_pulse = r_reg.wdt_rst;
  assign wake_pulse = r_reg.wake;
  assign vector_pulse = r_reg.vec;
  assign prefetch_pulse = r_reg.prefetch;
  assign osc_run = r_reg.osc_run;
  assign io_hold = r_reg.io_hold;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_run_timeout_resets;
    r_reg.tmo && r_reg.st != ST_SLEEP && master_clear_pin_n
      |=> wdt_reset_pulse && !r_reg.tof && !wake_pulse;
  endproperty
  a_run_timeout_resets: assert property (p_run_timeout_resets)
    else $error("run time-out did not reset");

  property p_sleep_timeout_wakes;
    r_reg.tmo && r_reg.st == ST_SLEEP && master_clear_pin_n
      |=> wake_pulse && !wdt_reset_pulse && !r_reg.tof ##1 !vector_pulse;
  endproperty
  a_sleep_timeout_wakes: assert property (p_sleep_timeout_wakes)
    else $error("sleep time-out did not wake cleanly");

  property p_fuse_off;
    !fuse_en |=> !r_reg.tmo;
  endproperty
  a_fuse_off: assert property (p_fuse_off)
    else $error("time-out with watchdog fuse cleared");

  property p_clear_zeroes;
    cmd_clr && master_clear_pin_n && !r_reg.tmo
      |=> r_reg.base_cnt == '0 && $stable(r_reg.option)
          && (!prescaler_assign_select || r_reg.pre_cnt == '0);
  endproperty
  a_clear_zeroes: assert property (p_clear_zeroes)
    else $error("clear did not zero the watchdog");

  property p_sleep_entry;
    cmd_sleep && !irq_act && master_clear_pin_n && !r_reg.tmo
      |=> !r_reg.pdf && r_reg.tof && !osc_run && io_hold && prefetch_pulse;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry flags wrong");

  property p_hold_in_sleep;
    r_reg.st == ST_SLEEP |-> io_hold && !osc_run;
  endproperty
  a_hold_in_sleep: assert property (p_hold_in_sleep)
    else $error("pins not held during sleep");

  property p_sleep_nop;
    cmd_sleep && irq_act && master_clear_pin_n && !r_reg.tmo
      |=> r_reg.st == ST_RUN && $stable(r_reg.pdf) && $stable(r_reg.tof);
  endproperty
  a_sleep_nop: assert property (p_sleep_nop)
    else $error("sleep with pending interrupt was not a no-op");

  property p_irq_vector;
    r_reg.st == ST_SLEEP && irq_wake && !r_reg.tmo && master_clear_pin_n
      |=> wake_pulse ##1 (vector_pulse == $past(r_reg.global_irq_enable, 2));
  endproperty
  a_irq_vector: assert property (p_irq_vector)
    else $error("interrupt wake vector wrong");

  property p_master_clear_pin_clears_gie;
    !master_clear_pin_n |=> !r_reg.global_irq_enable && r_reg.st == ST_RUN
                            && osc_run && !io_hold;
  endproperty
  a_master_clear_pin_clears_gie: assert property (p_master_clear_pin_clears_gie)
    else $error("master clear left interrupts enabled");

  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus request not answered in one cycle");

  c_wdt_reset: cover property (wdt_reset_pulse);
  c_wdt_wake: cover property (r_reg.st == ST_SLEEP && r_reg.tmo);
  c_irq_vector: cover property (wake_pulse ##1 vector_pulse);
  c_sleep_nop: cover property (cmd_sleep && irq_act);

endmodule : watchdog_sleep_wakeup_control

// ### tb.sv
// Self-checking testbench for the watchdog and sleep control block
`timescale 1ns/100ps
module tb;
  import watchdog_sleep_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic master_clear_pin_n = 1'b1;
  logic [7:0] config_fuses = 8'ha4;
  logic [7:0] irq_flags = 8'h00;
  logic wdt_reset_pulse, wake_pulse, vector_pulse, prefetch_pulse;
  logic osc_run, io_hold;
  logic [31:0] rd;
  int n_fail = 0;
  int n_tests = 0;
  int n;

  // Short periods keep each time-out within a few dozen cycles
  watchdog_sleep_wakeup_control #(.BASE_TICKS(4), .RC_DIV(2)) dut (
    .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .master_clear_pin_n(master_clear_pin_n), .config_fuses(config_fuses),
    .irq_flags(irq_flags), .wdt_reset_pulse(wdt_reset_pulse),
    .wake_pulse(wake_pulse), .vector_pulse(vector_pulse),
    .prefetch_pulse(prefetch_pulse), .osc_run(osc_run), .io_hold(io_hold));

  // 50 MHz clock
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", w, e, g);
    end
  endtask : chk

  // Edge first, so a release and the next request never share a step
  task automatic bus(input logic wr, input logic [13:0] idx,
                     input logic [31:0] wd, input logic [3:0] be);
    int k;
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      n_fail++;
      $display("CHECK FAILED waitrequest exp 0 got 1");
      end_of_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rchk(input string w, input logic [13:0] idx,
                      input logic [31:0] e);
    bus(1'b0, idx, 32'h0, 4'hf);
    chk(w, e, rd);
  endtask : rchk

  function automatic logic sel(input int i);
    case (i)
      0: return wdt_reset_pulse;
      1: return wake_pulse;
      2: return vector_pulse;
      default: return prefetch_pulse;
    endcase
  endfunction : sel

  // Cycles until a pulse shows, max+1 when it never does
  task automatic wait_out(input int i, input int max, input bit must);
    for (n = 0; n <= max; n++) begin
      #1;
      if (sel(i) === 1'b1) return;
      @(posedge clk_sys);
    end
    if (must) begin
      n_fail++;
      $display("CHECK FAILED pulse %0d exp 1 got 0", i);
      end_of_test();
    end
  endtask : wait_out

  task automatic do_reset();
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
  endtask : do_reset

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_values();
    rchk("status", IDX_STATUS, 32'h18);
    rchk("intctl", IDX_INTCTL, 32'h00);
    rchk("option", IDX_OPTION, {24'h0, OPTION_RESET});
    rchk("fuse", IDX_FUSE, 32'ha4);
    rchk("unmapped", 14'h0005, 32'h00);
    bus(1'b1, IDX_OPTION, 32'h00, 4'he);
    rchk("option_be", IDX_OPTION, 32'hff);
  endtask : t_reset_values

  // Each time-out resets the option register, so it is rewritten per pass
  task automatic t_period();
    logic [7:0] opt [4] = '{8'h07, 8'h08, 8'h09, 8'h0a};
    int cyc [4] = '{8, 8, 16, 32};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, IDX_OPTION, {24'h0, opt[i]}, 4'hf);
      bus(1'b1, IDX_CMD, 32'h1, 4'hf);
      wait_out(0, 80, 1'b1);
      chk("period", 1, n >= cyc[i] - 2 && n <= cyc[i] + 4);
      rchk("status_tmo", IDX_STATUS, 32'h08);
      rchk("option_wdt", IDX_OPTION, 32'hff);
    end
  endtask : t_period

  task automatic t_kick();
    bus(1'b1, IDX_OPTION, 32'h0a, 4'hf);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, IDX_CMD, 32'h1, 4'hf);
      wait_out(0, 18, 1'b0);
      chk("kicked", 1, n > 18);
    end
    rchk("option_kept", IDX_OPTION, 32'h0a);
    bus(1'b1, IDX_CMD, 32'h1, 4'hf);
    wait_out(0, 80, 1'b1);
    chk("period_kick", 1, n >= 30 && n <= 36);
  endtask : t_kick

  task automatic t_fuse_off();
    config_fuses <= 8'ha0;
    bus(1'b1, IDX_OPTION, 32'h07, 4'hf);
    bus(1'b1, IDX_CMD, 32'h1, 4'hf);
    wait_out(0, 60, 1'b0);
    chk("fuse_off", 1, n > 60);
    config_fuses <= 8'ha4;
  endtask : t_fuse_off

  task automatic t_sleep_wdt();
    bus(1'b1, IDX_OPTION, 32'h0a, 4'hf);
    bus(1'b1, IDX_CMD, 32'h1, 4'hf);
    bus(1'b1, IDX_CMD, 32'h2, 4'hf);
    wait_out(3, 3, 1'b1);
    chk("prefetch", 0, n);
    chk("osc_sleep", 0, osc_run);
    chk("hold_sleep", 1, io_hold);
    rchk("status_sleep", IDX_STATUS, 32'h11);
    wait_out(1, 60, 1'b1);
    chk("osc_wake", 1, osc_run);
    chk("hold_wake", 0, io_hold);
    wait_out(0, 20, 1'b0);
    chk("no_reset", 1, n > 20);
    rchk("status_wake", IDX_STATUS, 32'h00);
  endtask : t_sleep_wdt

  // Watchdog fuse off so only interrupts and master clear act
  task automatic t_irq();
    do_reset();
    config_fuses <= 8'ha0;
    bus(1'b1, IDX_IRQ_EN, 32'h11, 4'hf);
    rchk("irq_en", IDX_IRQ_EN, 32'h11);
    for (int g = 0; g < 2; g++) begin
      bus(1'b1, IDX_INTCTL, g ? 32'h80 : 32'h00, 4'hf);
      bus(1'b1, IDX_CMD, 32'h2, 4'hf);
      wait_out(3, 3, 1'b1);
      @(posedge clk_sys);
      irq_flags <= 8'h01;
      wait_out(1, 3, 1'b1);
      chk("irq_wake", 1, n);
      wait_out(2, 3, 1'b0);
      chk("vector", g ? 1 : 4, n);
      irq_flags <= 8'h00;
      rchk("status_irq", IDX_STATUS, 32'h10);
    end
    bus(1'b1, IDX_CMD, 32'h2, 4'hf);
    wait_out(3, 3, 1'b1);
    @(posedge clk_sys);
    irq_flags <= 8'h10;
    wait_out(1, 8, 1'b0);
    chk("no_wake", 9, n);
    @(posedge clk_sys);
    master_clear_pin_n <= 1'b0;
    @(posedge clk_sys);
    master_clear_pin_n <= 1'b1;
    irq_flags <= 8'h00;
    rchk("status_master_clear_pin", IDX_STATUS, 32'h10);
    rchk("intctl_master_clear_pin", IDX_INTCTL, 32'h00);
    chk("osc_master_clear_pin", 1, osc_run);
    chk("hold_master_clear_pin", 0, io_hold);
  endtask : t_irq

  task automatic t_pending();
    do_reset();
    bus(1'b1, IDX_IRQ_EN, 32'h01, 4'hf);
    irq_flags <= 8'h01;
    bus(1'b1, IDX_CMD, 32'h2, 4'hf);
    wait_out(3, 3, 1'b1);
    chk("osc_pending", 1, osc_run);
    rchk("status_pending", IDX_STATUS, 32'h18);
    irq_flags <= 8'h00;
  endtask : t_pending

  // ----------------------------------------------------------------------
  // Main sequence and run limit
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    t_reset_values();
    t_period();
    t_kick();
    t_fuse_off();
    t_sleep_wdt();
    t_irq();
    t_pending();
    end_of_test();
  end

  initial begin
    #(20 * 100000);
    n_fail++;
    $display("CHECK FAILED run time exp done got timeout");
    end_of_test();
  end
endmodule : tb
